/* File: rwu_pkg.sv */
// constants and types for the reset and watchdog unit
// What this block does
// - reset fuse at 1 makes pin external reset
// - power-up sets reset latch, clears delay timer
// - delay timer starts once reset pin high
// - delay timer on own RC tick, core held
// - power-on long delay; later resets mode-dependent
// - sleep watchdog timeout also runs delay timer
// - four sources: power, pin, watchdog, pin-change
// - watchdog on own RC tick, runs in sleep
// - watchdog timeout gives full device reset
// - watchdog reset clears timeout flag bit 4
// - watchdog fuse at 0 disables watchdog
// - watchdog nominal 18 ms, prescaled longer
// - option register assigns prescaler up to 1:128
// - clear instruction clears watchdog and prescaler
// - power-down instruction clears watchdog and prescaler
// - sleep wake flags: wdt 000, pin 010, change 110
// - power-up 011; wdt clears two; pin clears wake
// - flags hold until reset or power-down; pin pulse alone ignored
// - power-down sets timeout flag, clears power-down flag
// - bit 7 set only after pin-change wake
package rwu_pkg;
    localparam int CLK_NS = 8;
    localparam int RC_TICK_NS = 1000;
    localparam int RC_TICK_CYC = (RC_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int DRT_LONG_MS = 18;
    localparam int DRT_SHORT_US = 10;
    localparam int WDT_MS = 18;
    localparam logic [15:0] DRT_LONG_TICKS_DEF =
        16'(DRT_LONG_MS * 1000000 / RC_TICK_NS);
    localparam logic [15:0] DRT_SHORT_TICKS =
        16'(DRT_SHORT_US * 1000 / RC_TICK_NS);
    localparam logic [15:0] WDT_TICKS_DEF = 16'(WDT_MS * 1000000 / RC_TICK_NS);
    localparam int REG_ADDR_W = 2;
    localparam logic [1:0] OPTION_OFS = 2'h0;
    localparam logic [1:0] FLAGS_OFS = 2'h1;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam int PSA_BIT = 3;
    localparam int WAKE_BIT = 7;
    localparam int TO_BIT = 4;
    localparam int PD_BIT = 3;
    typedef enum logic [2:0] {
        INTERNAL_OSC_MODE = 3'b000,
        EXTERNAL_RC_MODE = 3'b001,
        HIGH_SPEED_CRYSTAL_MODE = 3'b010,
        STANDARD_CRYSTAL_MODE = 3'b011,
        LOW_POWER_CRYSTAL_MODE = 3'b100,
        EXTERNAL_CLOCK_MODE = 3'b101
    } rwu_osc_type;
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10,
        ST_SLEEP = 2'b11
    } rwu_state_type;
endpackage : rwu_pkg

/* File: rwu_top.sv */
// reset sequencer, delay timer and watchdog with reset-cause flags
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rwu_top #(
    parameter logic [15:0] DRT_LONG_TICKS = rwu_pkg::DRT_LONG_TICKS_DEF,
    parameter logic [15:0] WDT_TICKS = rwu_pkg::WDT_TICKS_DEF
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic EXTERNAL_RESET_PIN_N,
    input wire logic RESET_PIN_FUSE,
    input wire logic WATCHDOG_ENABLE_FUSE,
    input wire rwu_pkg::rwu_osc_type OSC_MODE,
    input wire logic WATCHDOG_CLEAR_INSTR,
    input wire logic POWERDOWN_INSTR,
    input wire logic PIN_CHANGE_WAKE,
    input wire logic [rwu_pkg::REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic [7:0] OPTION_OUT,
    output logic CORE_RESET,
    output logic SLEEP_MODE,
    output logic PIN_GP_IN
);
    import rwu_pkg::*;

    function automatic logic [6:0] ps_mask(input logic [2:0] rate);
        ps_mask = 7'((8'h01 << rate) - 8'h01);
    endfunction : ps_mask

    rwu_state_type state_r;
    rwu_state_type state_nxt;
    logic pin_s1_r;
    logic pin_s2_r;
    logic ext_rst_n;
    logic [7:0] rc_div_r;
    logic rc_tick;
    logic [15:0] drt_cnt_r;
    logic [15:0] drt_term;
    logic drt_done;
    logic por_r;
    logic [6:0] pre_r;
    logic [15:0] wdt_cnt_r;
    logic wdt_run;
    logic wdt_clr;
    logic wdt_step;
    logic wdt_to;
    logic [7:0] option_r;
    logic wake_r;
    logic timeout_flag_n_r;
    logic powerdown_flag_n_r;
    logic awake;
    logic pin_evt;
    logic wdt_evt;
    logic change_evt;
    logic sleep_evt;
    logic any_evt;
    logic long_mode;

    // reset pin crosses into MCLK here
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= EXTERNAL_RESET_PIN_N;
            pin_s2_r <= pin_s1_r;
        end
    end

    assign ext_rst_n = RESET_PIN_FUSE ? pin_s2_r : 1'b1;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PIN_GP_IN <= 1'b0;
        end else begin
            PIN_GP_IN <= RESET_PIN_FUSE ? 1'b0 : pin_s2_r;
        end
    end

    // RC oscillator stand-in, free running
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rc_div_r <= 8'h00;
        end else if (rc_div_r == 8'(RC_TICK_CYC - 1)) begin
            rc_div_r <= 8'h00;
        end else begin
            rc_div_r <= rc_div_r + 8'h01;
        end
    end

    assign rc_tick = (rc_div_r == 8'(RC_TICK_CYC - 1));

    assign awake = (state_r == ST_RUN) || (state_r == ST_SLEEP);
    assign pin_evt = awake && !ext_rst_n;
    assign wdt_evt = awake && wdt_to;
    assign change_evt = (state_r == ST_SLEEP) && PIN_CHANGE_WAKE;
    assign sleep_evt = (state_r == ST_RUN) && POWERDOWN_INSTR;
    assign any_evt = pin_evt || wdt_evt || change_evt || sleep_evt;

    assign long_mode = por_r ||
                       (OSC_MODE == HIGH_SPEED_CRYSTAL_MODE) ||
                       (OSC_MODE == STANDARD_CRYSTAL_MODE) ||
                       (OSC_MODE == LOW_POWER_CRYSTAL_MODE);
    assign drt_term = long_mode ? DRT_LONG_TICKS : DRT_SHORT_TICKS;
    assign drt_done = (state_r == ST_DELAY) && ext_rst_n && rc_tick &&
                      (drt_cnt_r == drt_term - 16'h0001);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HOLD: begin
                if (ext_rst_n) begin
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!ext_rst_n) begin
                    state_nxt = ST_HOLD;
                end else if (drt_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pin_evt || wdt_evt) begin
                    state_nxt = ST_HOLD;
                end else if (POWERDOWN_INSTR) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (pin_evt || wdt_evt || change_evt) begin
                    state_nxt = ST_HOLD;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_r <= ST_HOLD;
            CORE_RESET <= 1'b1;
            SLEEP_MODE <= 1'b0;
        end else begin
            state_r <= state_nxt;
            CORE_RESET <= (state_nxt == ST_HOLD) ||
                          (state_nxt == ST_DELAY);
            SLEEP_MODE <= (state_nxt == ST_SLEEP);
        end
    end

    // power-on marker picks the long delay once
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            por_r <= 1'b1;
        end else if (drt_done) begin
            por_r <= 1'b0;
        end
    end

    // delay timer counts RC ticks only in the delay state
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            drt_cnt_r <= 16'h0000;
        end else if (state_r != ST_DELAY || !ext_rst_n || drt_done) begin
            drt_cnt_r <= 16'h0000;
        end else if (rc_tick) begin
            drt_cnt_r <= drt_cnt_r + 16'h0001;
        end
    end

    assign wdt_run = WATCHDOG_ENABLE_FUSE && awake;
    assign wdt_clr = !wdt_run ||
                     ((state_r == ST_RUN) && WATCHDOG_CLEAR_INSTR) ||
                     sleep_evt;
    assign wdt_step = rc_tick && (!option_r[PSA_BIT] ||
                      pre_r == ps_mask(option_r[2:0]));
    assign wdt_to = wdt_run && !wdt_clr && wdt_step &&
                    (wdt_cnt_r == WDT_TICKS - 16'h0001);

    // prescaler only runs while assigned to the watchdog
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pre_r <= 7'h00;
        end else if (wdt_clr || !option_r[PSA_BIT]) begin
            pre_r <= 7'h00;
        end else if (rc_tick) begin
            if (pre_r == ps_mask(option_r[2:0])) begin
                pre_r <= 7'h00;
            end else begin
                pre_r <= pre_r + 7'h01;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wdt_cnt_r <= 16'h0000;
        end else if (wdt_clr || wdt_to) begin
            wdt_cnt_r <= 16'h0000;
        end else if (wdt_step) begin
            wdt_cnt_r <= wdt_cnt_r + 16'h0001;
        end
    end

    // option register, write-only, back to all ones on any reset
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            option_r <= OPTION_RST;
        end else if (pin_evt || wdt_evt || change_evt) begin
            option_r <= OPTION_RST;
        end else if (REG_WR && REG_ADDR == OPTION_OFS &&
                     state_r == ST_RUN) begin
            option_r <= REG_WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            OPTION_OUT <= OPTION_RST;
        end else begin
            OPTION_OUT <= option_r;
        end
    end

    // reset-cause flags, changed only by reset events and power-down
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wake_r <= 1'b0;
            timeout_flag_n_r <= 1'b1;
            powerdown_flag_n_r <= 1'b1;
        end else if (pin_evt) begin
            wake_r <= 1'b0;
            if (state_r == ST_SLEEP) begin
                timeout_flag_n_r <= 1'b1;
                powerdown_flag_n_r <= 1'b0;
            end
        end else if (wdt_evt) begin
            wake_r <= 1'b0;
            timeout_flag_n_r <= 1'b0;
            if (state_r == ST_SLEEP) begin
                powerdown_flag_n_r <= 1'b0;
            end
        end else if (change_evt) begin
            wake_r <= 1'b1;
            timeout_flag_n_r <= 1'b1;
            powerdown_flag_n_r <= 1'b0;
        end else if (sleep_evt) begin
            timeout_flag_n_r <= 1'b1;
            powerdown_flag_n_r <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD && REG_ADDR == FLAGS_OFS) begin
            REG_RDATA <= 8'h00;
            REG_RDATA[WAKE_BIT] <= wake_r;
            REG_RDATA[TO_BIT] <= timeout_flag_n_r;
            REG_RDATA[PD_BIT] <= powerdown_flag_n_r;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    chk_por_values: assert property (
        @(posedge MCLK) SYS_RST |=> CORE_RESET && drt_cnt_r == 16'h0000
            && !wake_r && timeout_flag_n_r && powerdown_flag_n_r)
        else $error("power-up state wrong");

    chk_hold_pin_low: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (!ext_rst_n && !awake) |=> CORE_RESET && drt_cnt_r == 16'h0000)
        else $error("delay ran while reset pin low");

    chk_release_cause: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        $fell(CORE_RESET) |-> $past(drt_done))
        else $error("core released without delay expiry");

    chk_fuse_ignores_pin: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (!RESET_PIN_FUSE && state_r == ST_RUN && !wdt_to)
            |=> state_r != ST_HOLD)
        else $error("pin reset while fuse programmed");

    chk_wdt_disabled: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        !WATCHDOG_ENABLE_FUSE |-> !wdt_to && wdt_cnt_r == 16'h0000)
        else $error("watchdog active while disabled");

    chk_wdt_reset_flag: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (wdt_evt && ext_rst_n) |=> !timeout_flag_n_r && !wake_r
            && state_r == ST_HOLD ##1 CORE_RESET)
        else $error("watchdog reset not flagged");

    chk_sleep_flags: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (sleep_evt && !pin_evt) |=> timeout_flag_n_r && !powerdown_flag_n_r
            && wdt_cnt_r == 16'h0000)
        else $error("power-down flags wrong");

    chk_change_wake: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (change_evt && !pin_evt && !wdt_evt) |=> wake_r
            && timeout_flag_n_r && !powerdown_flag_n_r)
        else $error("pin-change wake flags wrong");

    chk_clear_wdt: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (state_r == ST_RUN && WATCHDOG_CLEAR_INSTR)
            |=> wdt_cnt_r == 16'h0000 && pre_r == 7'h00)
        else $error("watchdog clear failed");

    chk_flags_hold: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        !any_evt |=> $stable({wake_r, timeout_flag_n_r,
            powerdown_flag_n_r}))
        else $error("flags changed without reset");

    chk_read_slot: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        !REG_RD |=> REG_RDATA == 8'h00)
        else $error("read data outside read slot");

    chk_pin_run_flags: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (pin_evt && state_r == ST_RUN) |=> !wake_r
            && $stable({timeout_flag_n_r, powerdown_flag_n_r}))
        else $error("pin reset changed timeout flags");

    chk_pin_sleep_flags: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (pin_evt && state_r == ST_SLEEP) |=> !wake_r
            && timeout_flag_n_r && !powerdown_flag_n_r)
        else $error("pin wake flags wrong");

    chk_wdt_sleep_flags: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (wdt_evt && ext_rst_n && state_r == ST_SLEEP) |=> !wake_r
            && !timeout_flag_n_r && !powerdown_flag_n_r)
        else $error("watchdog wake flags wrong");

    chk_wdt_run_pd: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (wdt_evt && ext_rst_n && state_r == ST_RUN)
            |=> $stable(powerdown_flag_n_r))
        else $error("watchdog reset changed power-down flag");

    chk_sleep_entry: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (sleep_evt && !pin_evt) |=> SLEEP_MODE && pre_r == 7'h00)
        else $error("sleep entry wrong");

    chk_direct_step: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (rc_tick && !option_r[PSA_BIT] && !wdt_clr && !wdt_to)
            |=> wdt_cnt_r == $past(wdt_cnt_r) + 16'h0001)
        else $error("watchdog missed a tick");

    chk_prescale_gap: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (rc_tick && option_r[PSA_BIT] && !wdt_clr
            && pre_r != ps_mask(option_r[2:0])) |=> $stable(wdt_cnt_r))
        else $error("watchdog stepped inside prescaler period");

    chk_option_write: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (REG_WR && REG_ADDR == OPTION_OFS && state_r == ST_RUN
            && !pin_evt && !wdt_evt) |=> option_r == $past(REG_WDATA))
        else $error("option write lost");

    chk_option_reset: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        (pin_evt || wdt_evt || change_evt) |=> option_r == OPTION_RST)
        else $error("option not reset");

    chk_gp_input: assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        RESET_PIN_FUSE |=> !PIN_GP_IN)
        else $error("pin input seen while reset function on");

endmodule : rwu_top
`default_nettype wire

/* File: rwu_core_model.sv */
// core and reset pin model driving the unit's far side
`timescale 1ns/1ps
`default_nettype none
module rwu_core_model (
    input wire logic clk,
    output logic pin_n,
    output logic clr,
    output logic pdn,
    output logic wake
);
    // pin starts held low; released pin goes to its pull-up level
    initial begin
        pin_n <= 1'b0;
        clr <= 1'b0;
        pdn <= 1'b0;
        wake <= 1'b0;
    end

    task automatic pin(input logic v);
        @(posedge clk);
        pin_n <= v;
    endtask : pin

    // 0 clear, 1 power-down, 2 pin-change wake; one-cycle pulses
    task automatic instr(input int k);
        @(posedge clk);
        clr <= (k == 0);
        pdn <= (k == 1);
        wake <= (k == 2);
        @(posedge clk);
        clr <= 1'b0;
        pdn <= 1'b0;
        wake <= 1'b0;
    endtask : instr
endmodule : rwu_core_model
`default_nettype wire

/* File: tb_rwu_top.sv */
// self-checking testbench for the reset and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module tb_rwu_top;
    import rwu_pkg::*;
    localparam int T = RC_TICK_CYC;
    localparam int SH = int'(DRT_SHORT_TICKS) * T;
    logic clk;
    logic sys_rst;
    logic pin_fuse;
    logic wdt_fuse;
    rwu_osc_type osc;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata, option_out;
    logic core_reset, sleep_mode, pin_gp_in, pin_n, clr, pdn, wake;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    rwu_core_model i_rwu_core_model (.clk(clk), .pin_n(pin_n), .clr(clr),
        .pdn(pdn), .wake(wake));

    rwu_top #(.DRT_LONG_TICKS(16'h0004), .WDT_TICKS(16'h0008)) i_rwu_top (
        .MCLK(clk), .SYS_RST(sys_rst), .EXTERNAL_RESET_PIN_N(pin_n),
        .RESET_PIN_FUSE(pin_fuse), .WATCHDOG_ENABLE_FUSE(wdt_fuse),
        .OSC_MODE(osc), .WATCHDOG_CLEAR_INSTR(clr), .POWERDOWN_INSTR(pdn),
        .PIN_CHANGE_WAKE(wake), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .OPTION_OUT(option_out), .CORE_RESET(core_reset),
        .SLEEP_MODE(sleep_mode), .PIN_GP_IN(pin_gp_in));

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            $display("BAD %0t run did not finish", $time);
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int n, input int lo, input int hi);
        n_compared++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("BAD %0t took %0d cycles, not %0d..%0d", $time, n, lo, hi);
        end
    endtask : chk_rng

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    // counts cycles until core reset reaches level v, then checks the span
    task automatic wait_rst(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset !== v && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_rng(n, lo, hi);
    endtask : wait_rst

    task automatic pin_pulse();
        i_rwu_core_model.pin(1'b0);
        repeat (6) @(posedge clk);
        #1;
        chk({7'h00, core_reset}, 8'h01);
        i_rwu_core_model.pin(1'b1);
    endtask : pin_pulse

    initial begin
        sys_rst <= 1'b1;
        pin_fuse <= 1'b1;
        wdt_fuse <= 1'b1;
        osc <= INTERNAL_OSC_MODE;
        reg_addr <= 2'h0;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (600) @(posedge clk);
        chk({7'h00, core_reset}, 8'h01);
        i_rwu_core_model.pin(1'b1);
        wait_rst(1'b0, 3 * T, 4 * T + 10);
        rd(2'h1, 8'h18);
        rd(2'h0, 8'h00);
        rd(2'h2, 8'h00);
        chk(option_out, OPTION_RST);
        $display("test power-up done");
        wr(2'h0, 8'h09);
        repeat (2) @(posedge clk);
        chk(option_out, 8'h09);
        wait_rst(1'b1, 12 * T, 16 * T + 10);
        wait_rst(1'b0, SH - T, SH + 10);
        rd(2'h1, 8'h08);
        chk(option_out, OPTION_RST);
        $display("test watchdog reset done");
        wr(2'h0, 8'h00);
        repeat (6) begin
            repeat (600) @(posedge clk);
            i_rwu_core_model.instr(0);
        end
        chk({7'h00, core_reset}, 8'h00);
        wait_rst(1'b1, 5 * T, 8 * T + 10);
        wait_rst(1'b0, SH - T, SH + 10);
        $display("test watchdog clear done");
        pin_pulse();
        wait_rst(1'b0, SH - T, SH + 10);
        rd(2'h1, 8'h08);
        $display("test pin reset done");
        wr(2'h0, 8'h00);
        repeat (700) @(posedge clk);
        i_rwu_core_model.instr(1);
        #1;
        chk({7'h00, sleep_mode}, 8'h01);
        rd(2'h1, 8'h10);
        wait_rst(1'b1, 5 * T, 8 * T + 10);
        wait_rst(1'b0, SH - T, SH + 10);
        rd(2'h1, 8'h00);
        $display("test sleep watchdog wake done");
        i_rwu_core_model.instr(1);
        repeat (50) @(posedge clk);
        pin_pulse();
        wait_rst(1'b0, SH - T, SH + 10);
        rd(2'h1, 8'h10);
        i_rwu_core_model.instr(1);
        i_rwu_core_model.instr(2);
        wait_rst(1'b1, 0, 2);
        wait_rst(1'b0, SH - T, SH + 10);
        rd(2'h1, 8'h90);
        $display("test sleep pin wakes done");
        @(posedge clk);
        wdt_fuse <= 1'b0;
        wr(2'h0, 8'h00);
        repeat (2000) @(posedge clk);
        chk({7'h00, core_reset}, 8'h00);
        pin_fuse <= 1'b0;
        i_rwu_core_model.pin(1'b0);
        repeat (6) @(posedge clk);
        chk({6'h00, core_reset, pin_gp_in}, 8'h00);
        i_rwu_core_model.pin(1'b1);
        repeat (6) @(posedge clk);
        chk({6'h00, core_reset, pin_gp_in}, 8'h01);
        pin_fuse <= 1'b1;
        $display("test fuses done");
        for (int m = 0; m < 6; m++) begin
            @(posedge clk);
            osc <= rwu_osc_type'(m);
            pin_pulse();
            if (m inside {2, 3, 4}) begin
                wait_rst(1'b0, 3 * T, 4 * T + 10);
            end else begin
                wait_rst(1'b0, SH - T, SH + 10);
            end
        end
        $display("test oscillator modes done");
        conclude();
    end
endmodule : tb_rwu_top
`default_nettype wire
